// ==== hw/irq_priority_standby_wake.v ====
// irq_priority_standby_wake.v: interrupt priority, vectoring and the
// standby modes with their wake and oscillator control
// assumes an APB master on ref_clk, a core that acks and returns by
// one-cycle pulses, and peripheral flags that already run on ref_clk
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "irq_map.vh"

module irq_priority_standby_wake #(
    parameter ADDR_W = 12
) (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    input wire extPinIrqZero,
    input wire extPinIrqOne,
    input wire resetPin_n,
    input wire [`V2_W-1:0] vec2Src,
    input wire [`V3_W-1:0] vec3Src,
    input wire [`V4_W-1:0] vec4Src,
    input wire [`V5_W-1:0] vec5Src,
    input wire [`V6_W-1:0] vec6Src,
    input wire [`V7_W-1:0] vec7Src,
    input wire [`V8_W-1:0] vec8Src,
    input wire [`V9_W-1:0] vec9Src,
    input wire watchdogReset,
    input wire lowVoltDetectReset,
    input wire watchdogLowRcRun,
    input wire baseTimerOnLowRc,
    input wire irqAck,
    input wire irqDone,
    output wire irqReq,
    output wire [`VEC_W-1:0] irqVector,
    output wire [1:0] irqLevel,
    output wire cpuStall,
    output wire periphHalt,
    output wire baseTimerRun,
    output wire irRxRun,
    output wire pllRun,
    output wire ceramicRun,
    output wire rcRun,
    output wire crystalRun,
    output wire lowRcRun,
    output wire [1:0] standbyMode
);

    // vector index to its address
    function [`VEC_W-1:0] vecAddr;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: vecAddr = `VEC_ADDR_0;
                4'h1: vecAddr = `VEC_ADDR_1;
                4'h2: vecAddr = `VEC_ADDR_2;
                4'h3: vecAddr = `VEC_ADDR_3;
                4'h4: vecAddr = `VEC_ADDR_4;
                4'h5: vecAddr = `VEC_ADDR_5;
                4'h6: vecAddr = `VEC_ADDR_6;
                4'h7: vecAddr = `VEC_ADDR_7;
                4'h8: vecAddr = `VEC_ADDR_8;
                default: vecAddr = `VEC_ADDR_9;
            endcase
        end
    endfunction

    // level of a vector from its select bit
    function [1:0] vecLevel;
        input [3:0] idx;
        input sel;
        begin
            if (!sel) begin
                vecLevel = `LVL_LOW;
            end else if (idx < 4'h2) begin
                vecLevel = `LVL_TOP;
            end else begin
                vecLevel = `LVL_HIGH;
            end
        end
    endfunction

    // register decode
    function isMapped;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `REG_LEVEL, `REG_ENABLE, `REG_PINCFG, `REG_STANDBY,
                `REG_OSC, `REG_STATUS, `REG_VECTOR: isMapped = 1'b1;
                default: isMapped = 1'b0;
            endcase
        end
    endfunction

    reg [`NUM_VEC-1:0] levelSel_q;
    reg [`NUM_VEC-1:0] enable_q;
    reg [3:0] pinCfg_q;
    reg [4:0] oscEn_q;
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg [31:0] prdata_q;
    reg [2:0] pinSyncA_q;
    reg [2:0] pinSyncB_q;
    reg [1:0] pinPrev_q;
    reg [1:0] edgeLatch_q;
    reg [1:0] edgeLatch_d;
    reg [2:0] inService_q;
    reg [2:0] inService_d;
    reg irqReq_q;
    reg [`VEC_W-1:0] irqVector_q;
    reg [1:0] irqLevel_q;
    reg [3:0] irqIdx_q;
    reg crystalEntry_q;
    reg lowRcEntry_q;
    reg btLowRcEntry_q;
    reg cpuStall_q;
    reg periphHalt_q;
    reg baseTimerRun_q;
    reg irRxRun_q;
    reg [4:0] oscRun_q;
    reg [4:0] oscRun_d;
    reg [`NUM_VEC-1:0] pending;
    reg [3:0] bestIdx;
    reg [1:0] bestLvl;
    reg [1:0] curLvl;
    reg [1:0] lvlI;
    reg [31:0] rdData;
    integer i;

    wire setupPhase = psel & ~penable;
    wire wrStrobe = psel & penable & pwrite;
    wire pinZero = pinSyncB_q[0];
    wire pinOne = pinSyncB_q[1];
    wire rstPinLow = ~pinSyncB_q[2];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~isMapped(paddr);
    assign prdata = prdata_q;

    // raw pins pass two flops before use
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSyncA_q <= 3'h4;
            pinSyncB_q <= 3'h4;
            pinPrev_q <= 2'h0;
        end else begin
            pinSyncA_q <= {resetPin_n, extPinIrqOne, extPinIrqZero};
            pinSyncB_q <= pinSyncA_q;
            pinPrev_q <= pinSyncB_q[1:0];
        end
    end

    wire zeroActive = pinCfg_q[`PIN0_HIGH] ? pinZero : ~pinZero;
    wire oneActive = pinCfg_q[`PIN1_HIGH] ? pinOne : ~pinOne;
    wire zeroEdge = pinCfg_q[`PIN0_HIGH] ? (pinZero & ~pinPrev_q[0]) :
        (~pinZero & pinPrev_q[0]);
    wire oneEdge = pinCfg_q[`PIN1_HIGH] ? (pinOne & ~pinPrev_q[1]) :
        (~pinOne & pinPrev_q[1]);
    wire zeroLevelOn = pinCfg_q[`PIN0_LEVEL] & zeroActive;
    wire oneLevelOn = pinCfg_q[`PIN1_LEVEL] & oneActive;
    wire ackNow = irqAck & irqReq_q;

    // edge latches, set wins over the ack clear
    always @* begin
        edgeLatch_d = edgeLatch_q;
        if (ackNow && irqIdx_q == 4'h0) begin
            edgeLatch_d[0] = 1'b0;
        end
        if (ackNow && irqIdx_q == 4'h1) begin
            edgeLatch_d[1] = 1'b0;
        end
        if (!pinCfg_q[`PIN0_LEVEL] && zeroEdge) begin
            edgeLatch_d[0] = 1'b1;
        end
        if (!pinCfg_q[`PIN1_LEVEL] && oneEdge) begin
            edgeLatch_d[1] = 1'b1;
        end
    end

    // request per vector, gated by enable
    always @* begin
        pending[0] = zeroLevelOn | edgeLatch_q[0];
        pending[1] = oneLevelOn | edgeLatch_q[1];
        pending[2] = |vec2Src;
        pending[3] = |vec3Src;
        pending[4] = |vec4Src;
        pending[5] = |vec5Src;
        pending[6] = |vec6Src;
        pending[7] = |vec7Src;
        pending[8] = |vec8Src;
        pending[9] = |vec9Src;
        pending = pending & enable_q;
    end

    always @* begin
        if (inService_q[2]) begin
            curLvl = `LVL_TOP;
        end else if (inService_q[1]) begin
            curLvl = `LVL_HIGH;
        end else if (inService_q[0]) begin
            curLvl = `LVL_LOW;
        end else begin
            curLvl = `LVL_NONE;
        end
    end

    always @* begin
        bestIdx = 4'h0;
        bestLvl = `LVL_NONE;
        lvlI = `LVL_NONE;
        for (i = `NUM_VEC - 1; i >= 0; i = i - 1) begin
            lvlI = vecLevel(i[3:0], levelSel_q[i]);
            if (pending[i] && lvlI >= bestLvl) begin
                bestIdx = i[3:0];
                bestLvl = lvlI;
            end
        end
    end

    // only a strictly higher level nests
    wire acceptable = (bestLvl != `LVL_NONE) && (bestLvl > curLvl);

    always @* begin
        inService_d = inService_q;
        if (irqDone) begin
            if (inService_q[2]) begin
                inService_d[2] = 1'b0;
            end else if (inService_q[1]) begin
                inService_d[1] = 1'b0;
            end else begin
                inService_d[0] = 1'b0;
            end
        end
        if (ackNow) begin
            inService_d[irqLevel_q - 2'h1] = 1'b1;
        end
    end

    // request recomputed each cycle, withdrawn for a cycle on ack or done
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqReq_q <= 1'b0;
            irqVector_q <= {`VEC_W{1'b0}};
            irqLevel_q <= `LVL_NONE;
            irqIdx_q <= 4'h0;
            inService_q <= 3'h0;
            edgeLatch_q <= 2'h0;
        end else begin
            inService_q <= inService_d;
            edgeLatch_q <= edgeLatch_d;
            irqReq_q <= acceptable & ~ackNow & ~irqDone;
            if (!irqReq_q || ackNow) begin
                irqVector_q <= vecAddr(bestIdx);
                irqLevel_q <= bestLvl;
                irqIdx_q <= bestIdx;
            end
        end
    end

    // vector held while offered
    assign irqReq = irqReq_q;
    assign irqVector = irqVector_q;
    assign irqLevel = irqLevel_q;

    wire resetWake = rstPinLow | watchdogReset | lowVoltDetectReset;
    // pins zero/one count only in level mode
    wire pinLevelWake = zeroLevelOn | oneLevelOn;
    wire holdWake = resetWake | pinLevelWake |
        vec2Src[`V2_PIN_TWO] | vec2Src[`V2_PIN_FOUR] |
        vec3Src[`V3_PIN_FIVE] | vec9Src[`V9_PORT_ZERO] |
        vec2Src[`V2_BUS_A] | vec2Src[`V2_BUS_B];
    wire xholdWake = holdWake | vec3Src[`V3_BASE_TIMER] |
        vec2Src[`V2_INFRARED];
    wire idleWake = resetWake | acceptable;

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            `MODE_RUN: begin
                if (wrStrobe && paddr == `REG_STANDBY) begin
                    mode_d = pwdata[1:0];
                end
            end
            `MODE_IDLE: begin
                if (idleWake) begin
                    mode_d = `MODE_RUN;
                end
            end
            `MODE_HOLD: begin
                if (holdWake) begin
                    mode_d = `MODE_RUN;
                end
            end
            `MODE_XHOLD: begin
                if (xholdWake) begin
                    mode_d = `MODE_RUN;
                end
            end
            default: mode_d = `MODE_RUN;
        endcase
    end

    wire entering = (mode_q == `MODE_RUN) && (mode_d != `MODE_RUN);
    wire lowRcNow = oscEn_q[`OSC_LOWRC] | watchdogLowRcRun;

    // oscillator enables for the next mode
    always @* begin
        oscRun_d = oscEn_q;
        oscRun_d[`OSC_LOWRC] = lowRcNow;
        case (mode_d)
            `MODE_HOLD: begin
                oscRun_d[`OSC_PLL] = 1'b0;
                oscRun_d[`OSC_CERAMIC] = 1'b0;
                oscRun_d[`OSC_RC] = 1'b0;
                oscRun_d[`OSC_CRYSTAL] = 1'b0;
                oscRun_d[`OSC_LOWRC] = watchdogLowRcRun;
            end
            `MODE_XHOLD: begin
                oscRun_d[`OSC_PLL] = 1'b0;
                oscRun_d[`OSC_CERAMIC] = 1'b0;
                oscRun_d[`OSC_RC] = 1'b0;
                oscRun_d[`OSC_CRYSTAL] = entering ? oscEn_q[`OSC_CRYSTAL]
                    : crystalEntry_q;
                // low rc frozen under base timer
                if (entering ? baseTimerOnLowRc : btLowRcEntry_q) begin
                    oscRun_d[`OSC_LOWRC] = entering ? lowRcNow
                        : lowRcEntry_q;
                end else begin
                    oscRun_d[`OSC_LOWRC] = watchdogLowRcRun;
                end
            end
            default: oscRun_d = oscRun_d;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `MODE_RUN;
            crystalEntry_q <= 1'b0;
            lowRcEntry_q <= 1'b0;
            btLowRcEntry_q <= 1'b0;
            cpuStall_q <= 1'b0;
            periphHalt_q <= 1'b0;
            baseTimerRun_q <= 1'b1;
            irRxRun_q <= 1'b1;
            oscRun_q <= `OSC_RESET;
        end else begin
            mode_q <= mode_d;
            if (entering) begin
                crystalEntry_q <= oscEn_q[`OSC_CRYSTAL];
                lowRcEntry_q <= lowRcNow;
                btLowRcEntry_q <= baseTimerOnLowRc;
            end
            cpuStall_q <= (mode_d != `MODE_RUN);
            periphHalt_q <= (mode_d == `MODE_HOLD) ||
                (mode_d == `MODE_XHOLD);
            baseTimerRun_q <= (mode_d != `MODE_HOLD);
            irRxRun_q <= (mode_d != `MODE_HOLD);
            oscRun_q <= oscRun_d;
        end
    end

    assign cpuStall = cpuStall_q;
    assign periphHalt = periphHalt_q;
    assign baseTimerRun = baseTimerRun_q;
    assign irRxRun = irRxRun_q;
    assign pllRun = oscRun_q[`OSC_PLL];
    assign ceramicRun = oscRun_q[`OSC_CERAMIC];
    assign rcRun = oscRun_q[`OSC_RC];
    assign crystalRun = oscRun_q[`OSC_CRYSTAL];
    assign lowRcRun = oscRun_q[`OSC_LOWRC];
    assign standbyMode = mode_q;

    // configuration writes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            levelSel_q <= {`NUM_VEC{1'b0}};
            enable_q <= {`NUM_VEC{1'b0}};
            pinCfg_q <= 4'h0;
            oscEn_q <= `OSC_RESET;
        end else if (wrStrobe) begin
            case (paddr)
                `REG_LEVEL: levelSel_q <= pwdata[`NUM_VEC-1:0];
                `REG_ENABLE: enable_q <= pwdata[`NUM_VEC-1:0];
                `REG_PINCFG: pinCfg_q <= pwdata[3:0];
                `REG_OSC: oscEn_q <= pwdata[4:0];
                default: oscEn_q <= oscEn_q;
            endcase
        end
    end

    // read mux, sampled in the setup phase
    always @* begin
        rdData = 32'h00000000;
        case (paddr)
            `REG_LEVEL: rdData[`NUM_VEC-1:0] = levelSel_q;
            `REG_ENABLE: rdData[`NUM_VEC-1:0] = enable_q;
            `REG_PINCFG: rdData[3:0] = pinCfg_q;
            `REG_STANDBY: rdData[1:0] = mode_q;
            `REG_OSC: rdData[4:0] = oscRun_q;
            `REG_STATUS: begin
                rdData[`NUM_VEC-1:0] = pending;
                rdData[`STAT_INSVC_LSB +: 3] = inService_q;
            end
            `REG_VECTOR: begin
                rdData[`VEC_W-1:0] = irqVector_q;
                rdData[`VECT_LVL_LSB +: 2] = irqLevel_q;
                rdData[`VECT_REQ_BIT] = irqReq_q;
            end
            default: rdData = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
        end else if (setupPhase) begin
            prdata_q <= rdData;
        end
    end

endmodule
`default_nettype wire

// ==== hw/irq_map.vh ====
// irq_map.vh: constants of the interrupt priority and standby wake block
// assumes it is included by bare name, by the block's design file, the checker and the testbench
`ifndef IRQ_MAP_VH
`define IRQ_MAP_VH
`define NUM_VEC 10
`define VEC_W 17
`define LVL_NONE 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_TOP 2'h3
`define VEC_ADDR_0 17'h00003
`define VEC_ADDR_1 17'h0000B
`define VEC_ADDR_2 17'h00013
`define VEC_ADDR_3 17'h0001B
`define VEC_ADDR_4 17'h00023
`define VEC_ADDR_5 17'h0002B
`define VEC_ADDR_6 17'h00033
`define VEC_ADDR_7 17'h0003B
`define VEC_ADDR_8 17'h00043
`define VEC_ADDR_9 17'h0004B
`define V2_W 6
`define V3_W 3
`define V4_W 5
`define V5_W 8
`define V6_W 2
`define V7_W 5
`define V8_W 7
`define V9_W 6
`define V2_PIN_TWO 0
`define V2_PIN_FOUR 2
`define V2_BUS_A 3
`define V2_BUS_B 4
`define V2_INFRARED 5
`define V3_PIN_FIVE 1
`define V3_BASE_TIMER 2
`define V9_PORT_ZERO 0
`define REG_LEVEL 12'h000
`define REG_ENABLE 12'h004
`define REG_PINCFG 12'h008
`define REG_STANDBY 12'h00C
`define REG_OSC 12'h010
`define REG_STATUS 12'h014
`define REG_VECTOR 12'h018
`define PIN0_LEVEL 0
`define PIN0_HIGH 1
`define PIN1_LEVEL 2
`define PIN1_HIGH 3
`define OSC_PLL 0
`define OSC_CERAMIC 1
`define OSC_RC 2
`define OSC_CRYSTAL 3
`define OSC_LOWRC 4
`define OSC_RESET 5'h04
`define STAT_INSVC_LSB 16
`define VECT_LVL_LSB 24
`define VECT_REQ_BIT 31
`define MODE_RUN 2'h0
`define MODE_IDLE 2'h1
`define MODE_HOLD 2'h2
`define MODE_XHOLD 2'h3
`endif

// ==== verif/irq_wake_checker.sv ====
// checker: timing relations at the ports of the irq and standby block
// bound to the block top by the testbench; sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "irq_map.vh"
module irq_wake_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic irqAck,
    input wire logic irqDone,
    input wire logic irqReq,
    input wire logic [`VEC_W-1:0] irqVector,
    input wire logic [1:0] irqLevel,
    input wire logic cpuStall,
    input wire logic periphHalt,
    input wire logic baseTimerRun,
    input wire logic irRxRun,
    input wire logic pllRun,
    input wire logic ceramicRun,
    input wire logic rcRun,
    input wire logic crystalRun,
    input wire logic watchdogReset,
    input wire logic lowVoltDetectReset,
    input wire logic [1:0] standbyMode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_offer_holds: assert property (
        irqReq && !irqAck && !irqDone |=> irqReq)
        else $error("offer dropped before ack");
    a_offer_stable: assert property (
        irqReq && !irqAck && !irqDone |=>
        $stable(irqVector) && $stable(irqLevel))
        else $error("offer changed while standing");
    a_ack_drops: assert property (irqReq && irqAck |=> !irqReq)
        else $error("offer stands after ack");
    a_level_set: assert property (irqReq |-> irqLevel != `LVL_NONE)
        else $error("offer without level");
    a_pin_level: assert property (
        irqReq && irqVector <= `VEC_ADDR_1 |->
        irqLevel == `LVL_LOW || irqLevel == `LVL_TOP)
        else $error("pin vector with wrong level");
    a_group_level: assert property (
        irqReq && irqVector > `VEC_ADDR_1 |->
        irqLevel == `LVL_LOW || irqLevel == `LVL_HIGH)
        else $error("group vector with wrong level");
    a_idle_core: assert property (
        standbyMode == `MODE_IDLE |-> cpuStall && !periphHalt)
        else $error("idle state wrong");
    a_deep_stop: assert property (
        standbyMode == `MODE_HOLD |-> cpuStall && periphHalt &&
        !pllRun && !ceramicRun && !rcRun && !crystalRun)
        else $error("deep sleep left something running");
    a_xtal_keep: assert property (
        standbyMode == `MODE_XHOLD |-> baseTimerRun && irRxRun &&
        periphHalt && !pllRun && !ceramicRun && !rcRun)
        else $error("crystal sleep state wrong");
    a_xtal_crystal: assert property (
        standbyMode == `MODE_XHOLD && $past(standbyMode) == `MODE_XHOLD
        |-> $stable(crystalRun))
        else $error("crystal changed in crystal sleep");
    a_reset_wake: assert property (
        standbyMode != `MODE_RUN && (watchdogReset || lowVoltDetectReset)
        |=> standbyMode == `MODE_RUN)
        else $error("reset source did not wake");
endmodule
`default_nettype wire

// ==== verif/core_model.sv ====
// core model: takes offered vectors after a set delay, returns on command
// assumes the same clock and reset as the irq block
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic irqReq,
    input wire logic ackEn,
    input wire logic [3:0] ackDelay,
    input wire logic doneCmd,
    output logic irqAck,
    output logic irqDone
);
    logic [3:0] waitCount_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAck <= 1'b0;
            irqDone <= 1'b0;
            waitCount_q <= 4'h0;
        end else begin
            irqAck <= 1'b0;
            irqDone <= doneCmd;
            waitCount_q <= (irqReq && !irqAck) ? waitCount_q + 4'h1 : 4'h0;
            // ack only a standing offer, one cycle long
            if (ackEn && irqReq && !irqAck && waitCount_q >= ackDelay)
                irqAck <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// testbench: drives the irq block over apb, sources and a core model
// assumes the block and its map header are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "irq_map.vh"
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic extPinIrqZero = 1'b0;
    logic extPinIrqOne = 1'b0;
    logic resetPin_n = 1'b1;
    logic watchdogReset = 1'b0;
    logic lowVoltDetectReset = 1'b0;
    logic watchdogLowRcRun = 1'b0;
    logic baseTimerOnLowRc = 1'b0;
    logic ackEn = 1'b0;
    logic doneCmd = 1'b0;
    logic [3:0] ackDelay = 4'h0;
    logic [41:0] src = 42'h0;
    wire pready, pslverr, irqAck, irqDone, irqReq, cpuStall, periphHalt;
    wire baseTimerRun, irRxRun, pllRun, ceramicRun, rcRun, crystalRun;
    wire lowRcRun;
    wire [31:0] prdata;
    wire [`VEC_W-1:0] irqVector;
    wire [1:0] irqLevel, standbyMode;
    wire [`V2_W-1:0] vec2Src = src[5:0];
    wire [`V3_W-1:0] vec3Src = src[8:6];
    wire [`V4_W-1:0] vec4Src = src[13:9];
    wire [`V5_W-1:0] vec5Src = src[21:14];
    wire [`V6_W-1:0] vec6Src = src[23:22];
    wire [`V7_W-1:0] vec7Src = src[28:24];
    wire [`V8_W-1:0] vec8Src = src[35:29];
    wire [`V9_W-1:0] vec9Src = src[41:36];
    int offs [2:9] = '{0, 6, 9, 14, 22, 24, 29, 36};
    int wid [2:9] = '{6, 3, 5, 8, 2, 5, 7, 6};
    // wake table: 10 watchdog, 11 low voltage, 12 reset pin, else source
    int wv [11] = '{10, 11, 12, 2, 2, 3, 9, 2, 2, 3, 2};
    int wb [11] = '{0, 0, 0, 0, 2, 1, 0, 3, 4, 2, 5};
    int errors = 0;
    int total_checks = 0;
    logic lastErr;
    logic [31:0] rd;
    irq_priority_standby_wake u_irq_priority_standby_wake (.*);
    core_model u_core_model (.*);
    always #4 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic timeout;
        errors++;
        $display("mismatch wait expected done seen timeout");
        print_verdict();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) timeout();
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitReq(input logic v);
        int n;
        n = 0;
        while (irqReq !== v && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 60) timeout();
    endtask
    task automatic stim(input int v, input int b, input logic val);
        case (v)
            10: watchdogReset <= val;
            11: lowVoltDetectReset <= val;
            12: resetPin_n <= !val;
            13: extPinIrqZero <= val;
            default: src[offs[v] + b] <= val;
        endcase
    endtask
    task automatic ackIt;
        ackEn <= 1'b1;
        @(posedge ref_clk);
        waitReq(1'b0);
        ackEn <= 1'b0;
    endtask
    task automatic doneIt;
        doneCmd <= 1'b1;
        @(posedge ref_clk);
        doneCmd <= 1'b0;
    endtask
    task automatic serve;
        ackIt();
        src <= 42'h0;
        repeat (4) @(posedge ref_clk);
        doneIt();
        repeat (3) @(posedge ref_clk);
    endtask
    function automatic int lvl(input int i, input logic [9:0] s);
        return s[i] ? (i < 2 ? 3 : 2) : 1;
    endfunction
    function automatic int best(input logic [9:0] m, input logic [9:0] s);
        int bi;
        int bl;
        bi = 0;
        bl = 0;
        for (int i = 0; i < 10; i++)
            if (m[i] && lvl(i, s) > bl) begin
                bi = i;
                bl = lvl(i, s);
            end
        return bi;
    endfunction
    task automatic sleep(input int md, input int v, input int b,
            input logic w);
        int n;
        if (md == 3) watchdogLowRcRun <= 1'b1;
        apb(1'b1, `REG_STANDBY, md);
        @(posedge ref_clk);
        chk("mode", standbyMode, md);
        if (md == 1) chk("idle rc", rcRun, 1'b1);
        if (md == 3) begin
            watchdogLowRcRun <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk("lowRcRun", lowRcRun, 1'b1);
        end
        stim(v, b, 1'b1);
        n = 0;
        while (standbyMode !== `MODE_RUN && n < 8) begin
            @(posedge ref_clk);
            n++;
        end
        chk("woken", standbyMode === `MODE_RUN, w);
        // an idle wake source is a request: held until it is served
        if (md != 1 || v > 9) stim(v, b, 1'b0);
        @(posedge ref_clk);
        if (!w) begin
            stim(10, 0, 1'b1);
            @(posedge ref_clk);
            stim(10, 0, 1'b0);
        end
        repeat (4) @(posedge ref_clk);
    endtask
    initial begin
        int s, v2, b2, bi;
        logic [9:0] m;
        void'($urandom(32'hACF1C8A3));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk("rcRun", rcRun, 1'b1);
        apb(1'b0, `REG_OSC, 32'h0);
        chk("osc", rd, 32'h4);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", lastErr, 1'b1);
        chk("unmapped rd", rd, 32'h0);
        apb(1'b1, `REG_ENABLE, 32'h3FC);
        for (int v = 2; v < 10; v++) begin
            for (int b = 0; b < wid[v]; b++) begin
                s = $urandom & 32'h3FC;
                v2 = ($urandom % 2) ? 2 + $urandom % 8 : v;
                b2 = (v2 == v) ? b : $urandom % wid[v2];
                ackDelay <= $urandom % 4;
                apb(1'b1, `REG_LEVEL, s);
                src <= (42'h1 << (offs[v] + b)) | (42'h1 << (offs[v2] + b2));
                m = 10'h0;
                m[v] = 1'b1;
                m[v2] = 1'b1;
                bi = best(m, s[9:0]);
                waitReq(1'b1);
                chk("vector", irqVector, 3 + 8 * bi);
                chk("level", irqLevel, lvl(bi, s[9:0]));
                serve();
            end
        end
        apb(1'b1, `REG_LEVEL, 32'h8);
        src <= 42'h1;
        waitReq(1'b1);
        ackIt();
        src <= 42'h201;
        repeat (10) @(posedge ref_clk);
        chk("equal level", irqReq, 1'b0);
        src <= 42'h241;
        waitReq(1'b1);
        chk("nested", irqVector, `VEC_ADDR_3);
        ackIt();
        src <= 42'h200;
        doneIt();
        repeat (5) @(posedge ref_clk);
        chk("still held", irqReq, 1'b0);
        doneIt();
        waitReq(1'b1);
        chk("retried", irqVector, `VEC_ADDR_4);
        serve();
        apb(1'b1, `REG_ENABLE, 32'h3);
        apb(1'b1, `REG_LEVEL, 32'h1);
        apb(1'b1, `REG_PINCFG, 32'hB);
        extPinIrqZero <= 1'b1;
        waitReq(1'b1);
        chk("pin0", {irqLevel, irqVector}, {`LVL_TOP, `VEC_ADDR_0});
        ackIt();
        extPinIrqZero <= 1'b0;
        repeat (4) @(posedge ref_clk);
        doneIt();
        extPinIrqOne <= 1'b1;
        @(posedge ref_clk);
        extPinIrqOne <= 1'b0;
        waitReq(1'b1);
        chk("pin1", {irqLevel, irqVector}, {`LVL_LOW, `VEC_ADDR_1});
        serve();
        apb(1'b1, `REG_ENABLE, 32'h3FC);
        sleep(1, 6, 0, 1'b1);
        waitReq(1'b1);
        serve();
        sleep(1, 10, 0, 1'b1);
        apb(1'b1, `REG_ENABLE, 32'h0);
        for (int k = 0; k < 9; k++) sleep(2, wv[k], wb[k], 1'b1);
        sleep(2, 5, 0, 1'b0);
        sleep(2, 3, 2, 1'b0);
        sleep(2, 2, 5, 1'b0);
        apb(1'b1, `REG_PINCFG, 32'h2);
        sleep(2, 13, 0, 1'b0);
        apb(1'b1, `REG_PINCFG, 32'h3);
        sleep(2, 13, 0, 1'b1);
        baseTimerOnLowRc <= 1'b1;
        for (int k = 0; k < 11; k++) sleep(3, wv[k], wb[k], 1'b1);
        sleep(3, 5, 0, 1'b0);
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        timeout();
    end
endmodule
bind irq_priority_standby_wake irq_wake_checker u_irq_wake_checker (.*);
`default_nettype wire
